//--- rtl/counter_timer_unit.sv
// four-channel counter/timer control: stop/restart, time constants, vector
// assumes an APB master on pclk, a synchronous external_count_trigger_input
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "ctc_regs.svh"
module counter_timer_unit
  import timer_unit_pkg::*;
(
  // clock, reset and freeze
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger or count inputs, one per channel
  input  wire logic [3:0]  external_count_trigger_input,
  // vectored acknowledge and observation
  input  wire logic        int_ack,
  output logic      [7:0]  ack_vector,
  output logic             ack_valid,
  output logic             irq,
  output logic      [3:0]  zero_pulse
);

  // decode of a channel port address, returns channel number or 4 when none
  // only the four aligned port words match; anything else is not a channel
  // port and falls to the shared registers or to the error answer
  function automatic logic [2:0] chan_of(input logic [11:0] a);
    unique case (a)
      `CH0_PORT_OFS: chan_of = 3'd0;
      `CH1_PORT_OFS: chan_of = 3'd1;
      `CH2_PORT_OFS: chan_of = 3'd2;
      `CH3_PORT_OFS: chan_of = 3'd3;
      default:       chan_of = 3'd4;
    endcase
  endfunction

  // highest-priority set bit, channel 0 first
  // lower channel numbers are tested last so that they win
  // the result is only used while at least one bit is set
  function automatic logic [1:0] prio_of(input logic [3:0] r);
    prio_of = 2'd3;
    if (r[3]) prio_of = 2'd3;
    if (r[2]) prio_of = 2'd2;
    if (r[1]) prio_of = 2'd1;
    if (r[0]) prio_of = 2'd0;
  endfunction

  // written constant to down-counter load value; zero stands for 256
  function automatic logic [8:0] full_count(input logic [7:0] v);
    if (v == 8'h00)
      full_count = 9'd256;
    else
      full_count = {1'b0, v};
  endfunction

  // bus decode, shared registers and per-channel summaries
  // the _reg/_next pairs are registered together in one process
  logic        wr_acc;
  logic        rd_acc;
  logic [2:0]  wr_ch;
  logic        mapped;
  logic [7:0]  vec_reg;
  logic [7:0]  vec_next;
  logic [3:0]  stat_reg;
  logic [3:0]  stat_next;
  logic [3:0]  mask_reg;
  logic [3:0]  mask_next;
  logic [7:0]  ackv_reg;
  logic [7:0]  ackv_next;
  logic        ackd_reg;
  logic        ackd_next;
  logic [31:0] rd_mux;
  logic [3:0]  zero_hit;
  logic [3:0]  running;
  logic [3:0]  trg_prev_reg;

  assign wr_acc  = psel & penable & pwrite & clk_en;
  // writes act at the access edge; reads are looked up in the setup cycle
  // so that prdata already stands from a flip-flop when pready is sampled
  assign rd_acc  = psel & ~penable & ~pwrite;
  assign wr_ch   = chan_of(paddr);
  assign mapped  = (wr_ch != 3'd4) || paddr == `IRQ_STATUS_OFS || paddr == `IRQ_MASK_OFS
                   || paddr == `CH_STATE_OFS || paddr == `VEC_READ_OFS;
  // every transfer is answered at once; unmapped offsets report an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  logic [3:0] tc_pend;

  // shared write decodes; the vector write needs channel 0 free of a pending
  // constant, otherwise that byte belongs to the constant
  logic       stat_clr;
  logic       mask_wr;
  logic       vec_wr;
  assign stat_clr = wr_acc && paddr == `IRQ_STATUS_OFS;
  assign mask_wr  = wr_acc && paddr == `IRQ_MASK_OFS;
  assign vec_wr   = wr_acc && wr_ch == 3'd0 && !pwdata[`CW_IS_CONTROL] && !tc_pend[0];

  // per-channel control, time constant and down-counter
  // each channel sits in one of four one-hot states: stopped, waiting for
  // its constant, waiting for a trigger edge, or running
  // a channel left running with a zero count wraps on its first tick, so
  // software must load a constant before it starts a channel
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      ch_state_t  st_reg,  st_next;
      ctrl_word_t cw_reg,  cw_next;
      logic [7:0] tc_reg,  tc_next;
      logic [8:0] cnt_reg, cnt_next;
      logic [7:0] pre_reg, pre_next;
      logic       pend_reg, pend_next;
      logic [1:0] dly_reg, dly_next;
      logic       wr_here;
      logic       trg_edge;
      logic       tick;
      logic [8:0] tc_full;
      logic [7:0] pre_reload;

      assign wr_here  = wr_acc && wr_ch == 3'(g);
      // edge detector; its history resets low like an idle input, so reset
      // itself never shows as an edge
      assign trg_edge = cw_reg.edge_rise ? (external_count_trigger_input[g] & ~trg_prev_reg[g])
                                         : (~external_count_trigger_input[g] & trg_prev_reg[g]);
      assign tc_full  = full_count(tc_reg);
      // the prescaler divides by 16 or by 256; its reload value is one less
      // because it counts down to zero and ticks there
      // it runs only while the channel runs, so a frozen or stopped channel
      // resumes from where its prescaler stood
      assign pre_reload = cw_reg.prescale_256 ? `PRESCALE_LARGE : `PRESCALE_SMALL;
      assign tc_pend[g] = pend_reg;
      assign running[g] = st_reg == CH_RUN;
      // timer ticks from the prescaler, counter ticks from the trigger edge
      assign tick = cw_reg.counter_mode ? trg_edge : (pre_reg == 8'h00);
      // the last tick of a count is the zero event
      assign zero_hit[g] = st_reg == CH_RUN && tick && cnt_reg == 9'd1;

      // next state of one channel: counting first, bus writes override
      always_comb begin
        st_next   = st_reg;
        cw_next   = cw_reg;
        tc_next   = tc_reg;
        cnt_next  = cnt_reg;
        pre_next  = pre_reg;
        pend_next = pend_reg;
        dly_next  = dly_reg;
        unique case (st_reg)
          CH_RUN: begin
            // timer mode reloads the prescaler each time it empties
            if (!cw_reg.counter_mode) begin
              if (pre_reg == 8'h00)
                pre_next = pre_reload;
              else
                pre_next = pre_reg - 8'h01;
            end
            // at one the tick reloads from the constant register
            if (tick) begin
              if (cnt_reg == 9'd1)
                cnt_next = tc_full;
              else
                cnt_next = cnt_reg - 9'd1;
            end
          end
          CH_WAIT_TRG: begin
            // edges inside the settling delay after a load are ignored
            if (dly_reg != 2'd0)
              dly_next = dly_reg - 2'd1;
            else if (trg_edge)
              st_next = CH_RUN;
          end
          CH_WAIT_TC: begin
            // held until the constant write below
            st_next = st_reg;
          end
          CH_STOPPED: begin
            // held until a control word or a pending constant write below
            st_next = st_reg;
          end
        endcase
        // a write while a constant is pending is always the constant
        if (wr_here && pend_reg) begin
          tc_next   = pwdata[7:0];
          pend_next = 1'b0;
          // a running channel keeps its count and takes the constant at zero
          if (st_reg != CH_RUN) begin
            cnt_next = full_count(pwdata[7:0]);
            pre_next = pre_reload;
            dly_next = 2'(`TRIG_DELAY_CYC);
            if (cw_reg.trig_select && !cw_reg.counter_mode)
              st_next = CH_WAIT_TRG;
            else
              st_next = CH_RUN;
          end
        end else if (wr_here && pwdata[`CW_IS_CONTROL]) begin
          // a control word stores its settings; stop only halts the count
          cw_next   = ctrl_word_t'(pwdata[7:0]);
          pend_next = pwdata[`CW_TC_FOLLOWS];
          if (pwdata[`CW_STOP])
            st_next = pwdata[`CW_TC_FOLLOWS] ? CH_WAIT_TC : CH_STOPPED;
          else if (st_reg == CH_STOPPED && !pwdata[`CW_TC_FOLLOWS])
            st_next = CH_RUN;
          else
            st_next = st_reg;
        end
      end

      // registers of one channel
      // clk_en low freezes every field, so a frozen channel neither counts
      // nor loses a pending constant
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_reg   <= CH_STOPPED;
          cw_reg   <= ctrl_word_t'(`CW_RESET_VAL);
          tc_reg   <= 8'h00;
          cnt_reg  <= 9'd0;
          pre_reg  <= 8'h00;
          pend_reg <= 1'b0;
          dly_reg  <= 2'd0;
        end else if (clk_en) begin
          st_reg   <= st_next;
          cw_reg   <= cw_next;
          tc_reg   <= tc_next;
          cnt_reg  <= cnt_next;
          pre_reg  <= pre_next;
          pend_reg <= pend_next;
          dly_reg  <= dly_next;
        end
      end
      // set by a zero with interrupts on, cleared by a one written to status;
      // when both fall in one cycle the set wins
      assign stat_next[g] = (zero_hit[g] & cw_reg.int_enable) |
                            (stat_reg[g] & ~(stat_clr & pwdata[g]));
    end
  endgenerate

  // shared vector, mask, acknowledge answer
  // bits 2..0 of the stored vector are kept but never delivered
  always_comb begin
    vec_next  = vec_reg;
    mask_next = mask_reg;
    ackv_next = ackv_reg;
    ackd_next = 1'b0;
    if (vec_wr) begin
      vec_next = pwdata[7:0];
    end
    if (mask_wr) begin
      mask_next = pwdata[3:0];
    end
    // answer an acknowledge only while an unmasked request stands;
    // the answer is a one-cycle pulse with the vector registered beside it
    if (int_ack && |(stat_reg & mask_reg)) begin
      ackv_next = {vec_reg[7:3], prio_of(stat_reg & mask_reg), 1'b0};
      ackd_next = 1'b1;
    end
  end

  // shared registers
  // prdata is loaded in the setup cycle of a read and then stands through
  // the access phase; the trigger history feeds all four edge detectors
  // clk_en low holds all of it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_reg      <= `VEC_RESET_VAL;
      stat_reg     <= 4'h0;
      mask_reg     <= 4'h0;
      ackv_reg     <= 8'h00;
      ackd_reg     <= 1'b0;
      trg_prev_reg <= 4'h0;
      prdata       <= 32'h0000_0000;
      zero_pulse   <= 4'h0;
    end else if (clk_en) begin
      vec_reg      <= vec_next;
      stat_reg     <= stat_next;
      mask_reg     <= mask_next;
      ackv_reg     <= ackv_next;
      ackd_reg     <= ackd_next;
      trg_prev_reg <= external_count_trigger_input;
      prdata       <= rd_mux;
      zero_pulse   <= zero_hit;
    end
  end

  // read data for the readback registers; channel ports are write-only
  // outside a read setup cycle the last value is held
  always_comb begin
    rd_mux = prdata;
    if (rd_acc) begin
      unique case (paddr)
        `IRQ_STATUS_OFS: rd_mux = {28'h0, stat_reg};
        `IRQ_MASK_OFS:   rd_mux = {28'h0, mask_reg};
        `CH_STATE_OFS:   rd_mux = {24'h0, tc_pend, running};
        `VEC_READ_OFS:   rd_mux = {24'h0, vec_reg};
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // limitations worth knowing:
  // - the prescaler only runs while the channel runs, so the first timer
  //   tick after a load comes one full prescaler period later
  // - a control word without a constant started from reset counts down from
  //   zero and wraps, so a constant should be loaded first
  // - edges on a trigger input during the settling delay after a load are
  //   dropped, not held over
  // - an acknowledge with nothing unmasked pending gives no answer; the
  //   last vector stays on ack_vector
  // - a write while clk_en is low is lost although pready answers it

  // level interrupt and the registered acknowledge answer
  assign irq        = |(stat_reg & mask_reg);
  assign ack_vector = ackv_reg;
  assign ack_valid  = ackd_reg;
endmodule

//--- rtl/ctc_pkg.sv
// types shared by the counter/timer channel control block
// no assumptions beyond a SystemVerilog compiler
package timer_unit_pkg;
  typedef enum logic [3:0] {
    CH_STOPPED = 4'h1,
    CH_WAIT_TC = 4'h2,
    CH_WAIT_TRG = 4'h4,
    CH_RUN = 4'h8
  } ch_state_t;

  typedef struct packed {
    logic       int_enable;
    logic       counter_mode;
    logic       prescale_256;
    logic       edge_rise;
    logic       trig_select;
    logic       tc_follows;
    logic       stop;
    logic       is_control;
  } ctrl_word_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] vector;
  } vec_answer_t;
endpackage

//--- rtl/ctc_regs.svh
// register offsets, field positions, reset values and timing counts of the counter/timer channels
// included by the package-using design file; definitions only
`ifndef TIMER_UNIT_REGS_SVH
`define TIMER_UNIT_REGS_SVH
`define CH0_PORT_OFS      12'h000
`define CH1_PORT_OFS      12'h004
`define CH2_PORT_OFS      12'h008
`define CH3_PORT_OFS      12'h00C
`define IRQ_STATUS_OFS    12'h010
`define IRQ_MASK_OFS      12'h014
`define CH_STATE_OFS      12'h018
`define VEC_READ_OFS      12'h01C
`define CW_IS_CONTROL     0
`define CW_STOP           1
`define CW_TC_FOLLOWS     2
`define CW_TRIG_SELECT    3
`define CW_EDGE_RISE      4
`define CW_PRESCALE_256   5
`define CW_COUNTER_MODE   6
`define CW_INT_ENABLE     7
`define CW_RESET_VAL      8'h03
`define VEC_RESET_VAL     8'h00
`define PRESCALE_SMALL    8'h0F
`define PRESCALE_LARGE    8'hFF
`define TRIG_DELAY_NS     8
`define TRIG_DELAY_CYC    ((`TRIG_DELAY_NS + 3) / 4)
`endif

//--- tb/counter_timer_unit_sva.sv
// port checker for the counter/timer unit
// bound from tb; single pclk domain, presetn async low
`timescale 1ns/1ps
module counter_timer_unit_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        int_ack,
  input wire logic        irq,
  input wire logic        ack_valid,
  input wire logic [7:0]  ack_vector,
  input wire logic [3:0]  zero_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decode, acknowledge and zero pulse relations
  bad_addr_a: assert property (psel && penable && paddr > 12'h01C |-> pslverr)
    else $error("unmapped access without error");
  ready_high_a: assert property (psel && penable |-> pready)
    else $error("access not answered");
  ack_answer_a: assert property (int_ack && irq && clk_en |=> ack_valid)
    else $error("acknowledge gave no vector");
  ack_quiet_a: assert property (int_ack && !irq |=> !ack_valid)
    else $error("vector without request");
  ack_cause_a: assert property (ack_valid |-> $past(int_ack))
    else $error("vector without acknowledge");
  vec_low_bit_a: assert property (ack_valid |-> !ack_vector[0])
    else $error("vector bit 0 set");
  vec_hold_a: assert property (!ack_valid |-> $stable(ack_vector))
    else $error("vector changed outside acknowledge");
  zero_pulse_a: assert property ($past(clk_en) |-> (zero_pulse & $past(zero_pulse)) == 4'h0)
    else $error("zero pulse longer than one cycle");
endmodule

//--- tb/proc_core_model.sv
// processor side of vectored acknowledge
// assumes ack_valid follows int_ack by one edge
`timescale 1ns/1ps
module proc_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       req,
  input  wire logic       irq,
  input  wire logic       ack_valid,
  input  wire logic [7:0] ack_vector,
  output logic            int_ack,
  output logic            done,
  output logic [7:0]      vec
);
  // one acknowledge cycle per request, vector latched when valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ack <= 1'b0;
      done    <= 1'b0;
      vec     <= 8'h00;
    end else begin
      int_ack <= req && irq && !int_ack && !done && !ack_valid;
      if (ack_valid) begin
        vec  <= ack_vector;
        done <= 1'b1;
      end else if (!req) begin
        done <= 1'b0;
      end
    end
  end
endmodule

//--- tb/tb.sv
// bench for the counter/timer unit: apb writes, trigger edges, acknowledges
// assumes read data standing in the access phase and pready answering at once
`timescale 1ns/1ps
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack_req = 0, clk_en = 1;
  logic        pready, pslverr, int_ack, ack_valid, irq, ack_done, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0]  trig = 4'h0, zero_pulse;
  logic [7:0]  ack_vector, vec;
  int          err_count = 0, compares = 0, cyc = 0, zc = 0, base;
  counter_timer_unit counter_timer_unit_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_count_trigger_input(trig), .int_ack, .ack_vector, .ack_valid,
    .irq, .zero_pulse);
  proc_core_model proc_core_model_inst (.pclk, .presetn, .req(ack_req), .irq, .ack_valid, .ack_vector,
    .int_ack, .done(ack_done), .vec);
  initial forever #2 pclk = ~pclk;
  // cycle limit and channel 0 zero counter
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (zero_pulse[0] === 1'b1) zc <= zc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; error and read data taken at the edge that samples pready
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rdv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic edges(logic [3:0] m, int n);
    repeat (n) begin
      trig <= trig | m;
      repeat (2) @(posedge pclk);
      trig <= trig & ~m;
      repeat (2) @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic ack(logic [7:0] exp);
    ack_req <= 1'b1;
    repeat (20) if (ack_done !== 1'b1) @(posedge pclk);
    ack_req <= 1'b0;
    chk("vector", exp, vec);
    repeat (2) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("counts: %0d mismatches, %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, err);
    apb(1, 12'h000, 32'hAE);
    apb(1, 12'h014, 32'hF);
    apb(1, 12'h000, 32'hD7);
    edges(4'h1, 4);
    apb(0, 12'h018, 0);
    chk("held count", 0, zc);
    chk("pending state", 32'h10, rdv);
    apb(1, 12'h000, 32'h03);
    apb(0, 12'h018, 0);
    chk("armed state", 32'h01, rdv);
    edges(4'h1, 6);
    chk("zero count", 2, zc);
    chk("irq", 1, irq);
    ack(8'hA8);
    $display("test load and vector done");
    apb(1, 12'h000, 32'hD1);
    edges(4'h1, 3);
    chk("run on", 3, zc);
    apb(1, 12'h000, 32'hD5);
    apb(1, 12'h000, 32'h01);
    edges(4'h1, 3);
    chk("old count", 4, zc);
    edges(4'h1, 2);
    chk("new count", 6, zc);
    apb(1, 12'h000, 32'hC3);
    edges(4'h1, 4);
    apb(0, 12'h018, 0);
    chk("stopped count", 6, zc);
    chk("stopped state", 0, rdv);
    apb(1, 12'h000, 32'hD1);
    apb(0, 12'h018, 0);
    chk("resumed state", 1, rdv);
    $display("test stop and restart done");
    apb(1, 12'h000, 32'hD7);
    apb(1, 12'h000, 32'h00);
    base = zc;
    edges(4'h1, 255);
    chk("255 edges", base, zc);
    edges(4'h1, 1);
    chk("256 edges", base + 1, zc);
    apb(1, 12'h008, 32'hD7);
    apb(1, 12'h008, 32'h01);
    apb(1, 12'h000, 32'hD7);
    apb(1, 12'h000, 32'h01);
    apb(1, 12'h010, 32'hF);
    edges(4'h5, 1);
    apb(0, 12'h010, 0);
    chk("status", 32'h05, rdv);
    ack(8'hA8);
    apb(1, 12'h010, 32'h1);
    ack(8'hAC);
    apb(1, 12'h014, 32'h0);
    chk("masked irq", 0, irq);
    $display("test priority done");
    apb(1, 12'h014, 32'hF);
    apb(1, 12'h010, 32'hF);
    apb(1, 12'h004, 32'h9F);
    apb(1, 12'h004, 32'h02);
    apb(0, 12'h018, 0);
    chk("trigger wait", 32'h05, rdv);
    edges(4'h2, 1);
    apb(0, 12'h018, 0);
    chk("timer run", 32'h07, rdv);
    clk_en <= 1'b0;
    repeat (64) @(posedge pclk);
    clk_en <= 1'b1;
    apb(0, 12'h010, 0);
    chk("frozen status", 32'h00, rdv);
    repeat (40) @(posedge pclk);
    apb(0, 12'h010, 0);
    chk("timer status", 32'h02, rdv);
    $display("test timer and freeze done");
    conclude();
  end
endmodule
bind counter_timer_unit counter_timer_unit_sva counter_timer_unit_sva_inst (.*);
